// File: common/csbuf_pkg.sv
// package: constants and carriers for the channel status block buffer
package csbuf_pkg;
  localparam int          BLOCK_BYTES     = 24;
  localparam int          RESERVED_BYTES  = 5;
  localparam int          FIFO_DEPTH      = 32;
  localparam logic [7:0]  ADDR_BUF_BASE   = 8'h20;
  localparam logic [7:0]  ADDR_BUF_LAST   = 8'h4f;
  localparam logic [7:0]  ADDR_CTRL       = 8'h10;
  localparam logic [7:0]  ADDR_STATUS     = 8'h11;
  localparam logic [7:0]  RESET_CTRL      = 8'h00;
  localparam logic [15:0] RESET_WORD      = 16'h0000;
  localparam logic [7:0]  CRC_POLY        = 8'h1d;
  localparam logic [7:0]  CRC_INIT        = 8'hff;
  localparam int          CTRL_INH_DE     = 0;
  localparam int          CTRL_INH_EF     = 1;
  localparam int          CTRL_RESERVE    = 2;
  localparam int          CTRL_IEN_DE     = 3;
  localparam int          CTRL_IEN_EF     = 4;
  localparam int          STAT_DE         = 0;
  localparam int          STAT_EF         = 1;
  localparam int          PROFESSIONAL_FORMAT_BIT = 7;

  typedef struct packed {
    logic [4:0]  index;
    logic [15:0] word;
  } cap_word_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_s;
endpackage : csbuf_pkg

// File: rtl/csbuf_fifo.sv
// file: fifo holding captured status words before the capture buffer
`timescale 1ns/100ps
`default_nettype none
module csbuf_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : csbuf_fifo
`default_nettype wire

// File: rtl/chan_status_block_buffer.sv
// file: three-stage channel status block buffer with host port
`timescale 1ns/100ps
`default_nettype none
module chan_status_block_buffer #(
  parameter int NBYTES = csbuf_pkg::BLOCK_BYTES
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  // receiver side, one bit per channel per frame
  input  wire logic                 rx_bit_valid,
  input  wire logic                 rx_bit_a,
  input  wire logic                 rx_bit_b,
  input  wire logic                 rx_block_start,
  output logic                      rx_bit_ready,
  // transmitter side
  input  wire logic                 tx_block_boundary,
  input  wire logic                 tx_bit_req,
  output logic                      tx_bit_a,
  output logic                      tx_bit_b,
  // control port
  input  wire csbuf_pkg::host_req_s host_req,
  input  wire logic                 run_enable,
  output logic [7:0]                host_rdata,
  output logic                      host_rvalid,
  // user data store, host reached
  input  wire logic                 user_wr,
  input  wire logic [4:0]           user_index,
  input  wire logic [15:0]          user_wdata,
  output logic [15:0]               user_rdata,
  // transfer interrupt
  output logic                      irq
);
  logic [15:0] cap_r  [NBYTES];
  logic [15:0] host_r [NBYTES];
  logic [15:0] tx_r   [NBYTES];
  logic [15:0] user_r [NBYTES];
  logic [7:0]  ctrl_r;
  logic [1:0]  stat_r;
  logic [4:0]  bit_cnt_r;
  logic [15:0] shift_r;
  logic [4:0]  cap_idx_r;
  logic        cap_full_r;
  logic [4:0]  tx_idx_r;
  logic [2:0]  tx_bit_r;
  logic        tx_a_r;
  logic        tx_b_r;
  logic [7:0]  rdata_r;
  logic        rvalid_r;
  logic        irq_r;
  logic [15:0] urd_r;
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  csbuf_pkg::cap_word_s fifo_in;
  csbuf_pkg::cap_word_s fifo_out;
  logic        do_de;
  logic        do_ef;
  logic        host_hit;
  logic [4:0]  host_idx;
  logic [7:0]  crc_a;
  logic [7:0]  crc_b;
  logic        professional_a;
  logic        professional_b;

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[7] ^ d[i]) ? ((r << 1) ^ csbuf_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc8

  // serial capture: msb first, a word completes every 8 frames
  assign rx_bit_ready  = fifo_in_ready;
  assign fifo_in_valid = rx_bit_valid && fifo_in_ready && (bit_cnt_r[2:0] == 3'd7);
  assign fifo_in.index = cap_idx_r;
  assign fifo_in.word  = {shift_r[14:8], rx_bit_a, shift_r[6:0], rx_bit_b};

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_r <= '0;
      shift_r   <= csbuf_pkg::RESET_WORD;
      cap_idx_r <= '0;
    end else if (rx_bit_valid && fifo_in_ready) begin
      if (rx_block_start) begin
        bit_cnt_r <= 5'd1;
        cap_idx_r <= '0;
        shift_r   <= {7'h00, rx_bit_a, 7'h00, rx_bit_b};
      end else begin
        shift_r   <= {shift_r[14:8], rx_bit_a, shift_r[6:0], rx_bit_b};
        bit_cnt_r <= (bit_cnt_r[2:0] == 3'd7) ? '0 : bit_cnt_r + 5'd1;
        if (bit_cnt_r[2:0] == 3'd7) begin
          cap_idx_r <= (cap_idx_r == 5'(NBYTES-1)) ? '0 : cap_idx_r + 5'd1;
        end
      end
    end
  end

  csbuf_fifo #(
    .WIDTH ($bits(csbuf_pkg::cap_word_s)),
    .DEPTH (csbuf_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (!do_de),
    .out_data  (fifo_out)
  );

  // capture buffer written from fifo; full flag marks a whole block
  always_ff @(posedge ref_clk) begin
    if (fifo_out_valid && !do_de) begin
      cap_r[fifo_out.index] <= fifo_out.word;
    end
  end

  // one-cycle boundary pulse: an inhibited boundary is lost, never held over
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cap_full_r <= 1'b0;
    end else begin
      cap_full_r <= fifo_out_valid && !do_de && fifo_out.index == 5'(NBYTES-1);
    end
  end

  // whole block boundaries; inhibited boundaries are dropped
  assign do_de = cap_full_r && !ctrl_r[csbuf_pkg::CTRL_INH_DE];
  assign do_ef = tx_block_boundary && !ctrl_r[csbuf_pkg::CTRL_INH_EF];

  assign host_idx = 5'((host_req.addr - csbuf_pkg::ADDR_BUF_BASE) >> 1);
  assign host_hit = run_enable && host_req.addr >= csbuf_pkg::ADDR_BUF_BASE
                    && host_req.addr <= csbuf_pkg::ADDR_BUF_LAST;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NBYTES; i++) begin
        host_r[i] <= csbuf_pkg::RESET_WORD;
      end
    end else begin
      for (int i = 0; i < NBYTES; i++) begin
        if (do_de && (!ctrl_r[csbuf_pkg::CTRL_RESERVE] || i >= csbuf_pkg::RESERVED_BYTES)) begin
          host_r[i] <= cap_r[i];
        end
      end
      if (host_req.wr && host_hit) begin
        if (host_req.addr[0]) begin
          host_r[host_idx][7:0] <= host_req.wdata;
        end else begin
          host_r[host_idx][15:8] <= host_req.wdata;
        end
      end
    end
  end

  // check byte over first 23 bytes of each channel
  assign professional_a = host_r[0][8 + csbuf_pkg::PROFESSIONAL_FORMAT_BIT];
  assign professional_b = host_r[0][csbuf_pkg::PROFESSIONAL_FORMAT_BIT];
  always_comb begin
    crc_a = csbuf_pkg::CRC_INIT;
    crc_b = csbuf_pkg::CRC_INIT;
    for (int i = 0; i < NBYTES - 1; i++) begin
      crc_a = crc8(crc_a, host_r[i][15:8]);
      crc_b = crc8(crc_b, host_r[i][7:0]);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NBYTES; i++) begin
        tx_r[i] <= csbuf_pkg::RESET_WORD;
      end
    end else if (do_ef) begin
      for (int i = 0; i < NBYTES - 1; i++) begin
        tx_r[i] <= host_r[i];
      end
      tx_r[NBYTES-1][15:8] <= professional_a ? crc_a : host_r[NBYTES-1][15:8];
      tx_r[NBYTES-1][7:0]  <= professional_b ? crc_b : host_r[NBYTES-1][7:0];
    end
  end

  // transmit serialiser, msb first
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_idx_r <= '0;
      tx_bit_r <= 3'd7;
      tx_a_r   <= 1'b0;
      tx_b_r   <= 1'b0;
    end else if (tx_block_boundary) begin
      tx_idx_r <= '0;
      tx_bit_r <= 3'd7;
    end else if (tx_bit_req) begin
      tx_a_r   <= tx_r[tx_idx_r][8 + tx_bit_r];
      tx_b_r   <= tx_r[tx_idx_r][tx_bit_r];
      tx_bit_r <= tx_bit_r - 3'd1;
      if (tx_bit_r == 3'd0) begin
        tx_idx_r <= (tx_idx_r == 5'(NBYTES-1)) ? '0 : tx_idx_r + 5'd1;
      end
    end
  end

  // control, status (write one to clear, set wins) and readback
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= csbuf_pkg::RESET_CTRL;
    end else if (host_req.wr && host_req.addr == csbuf_pkg::ADDR_CTRL) begin
      ctrl_r <= host_req.wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_r <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == 0) ? do_de : do_ef) begin
          stat_r[i] <= 1'b1;
        end else if (host_req.wr && host_req.addr == csbuf_pkg::ADDR_STATUS
                     && host_req.wdata[i]) begin
          stat_r[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (stat_r[csbuf_pkg::STAT_DE] && ctrl_r[csbuf_pkg::CTRL_IEN_DE])
            || (stat_r[csbuf_pkg::STAT_EF] && ctrl_r[csbuf_pkg::CTRL_IEN_EF]);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r  <= '0;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= host_req.rd;
      if (host_req.rd) begin
        if (host_hit) begin
          rdata_r <= host_req.addr[0] ? host_r[host_idx][7:0] : host_r[host_idx][15:8];
        end else if (host_req.addr == csbuf_pkg::ADDR_CTRL) begin
          rdata_r <= ctrl_r;
        end else if (host_req.addr == csbuf_pkg::ADDR_STATUS) begin
          rdata_r <= {6'h00, stat_r};
        end else begin
          rdata_r <= '0;
        end
      end
    end
  end

  // user store, kept for the host
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      urd_r <= '0;
      for (int i = 0; i < NBYTES; i++) begin
        user_r[i] <= csbuf_pkg::RESET_WORD;
      end
    end else begin
      if (user_wr && run_enable) begin
        user_r[user_index] <= user_wdata;
      end
      urd_r <= user_r[user_index];
    end
  end

  assign tx_bit_a    = tx_a_r;
  assign tx_bit_b    = tx_b_r;
  assign host_rdata  = rdata_r;
  assign host_rvalid = rvalid_r;
  assign user_rdata  = urd_r;
  assign irq         = irq_r;

  // checks sit by the transfer logic; writes are excluded where they may win
  a_de_sets_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
    do_de |=> stat_r[csbuf_pkg::STAT_DE]) else $error("de flag not set");
  a_ef_inhibit: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ctrl_r[csbuf_pkg::CTRL_INH_EF] && tx_block_boundary
    |=> tx_r[1] == $past(tx_r[1])) else $error("ef ran inhibited");
  a_de_inhibit: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ctrl_r[csbuf_pkg::CTRL_INH_DE] && !host_req.wr
    |=> host_r[NBYTES-1] == $past(host_r[NBYTES-1])) else $error("de ran inhibited");
  a_reserve_keeps: assert property (@(posedge ref_clk) disable iff (!reset_n)
    do_de && ctrl_r[csbuf_pkg::CTRL_RESERVE] && !host_req.wr
    |=> host_r[0] == $past(host_r[0])) else $error("reserved byte changed");
  a_full_copy: assert property (@(posedge ref_clk) disable iff (!reset_n)
    do_de && !ctrl_r[csbuf_pkg::CTRL_RESERVE] && !host_req.wr
    |=> host_r[0] == $past(cap_r[0])) else $error("byte 0 not copied");
  a_ef_copy: assert property (@(posedge ref_clk) disable iff (!reset_n)
    do_ef |=> tx_r[1] == $past(host_r[1])) else $error("tx copy wrong");
  a_crc_insert: assert property (@(posedge ref_clk) disable iff (!reset_n)
    do_ef && professional_a |=> tx_r[NBYTES-1][15:8] == $past(crc_a))
    else $error("check byte missing");
  a_plain_last: assert property (@(posedge ref_clk) disable iff (!reset_n)
    do_ef && !professional_b |=> tx_r[NBYTES-1][7:0] == $past(host_r[NBYTES-1][7:0]))
    else $error("last byte altered");
  a_irq_follows: assert property (@(posedge ref_clk) disable iff (!reset_n)
    do_ef && ctrl_r[csbuf_pkg::CTRL_IEN_EF] ##1 ctrl_r[csbuf_pkg::CTRL_IEN_EF] |=> irq)
    else $error("irq missing");
  a_irq_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !stat_r[csbuf_pkg::STAT_DE] && !stat_r[csbuf_pkg::STAT_EF] |=> !irq)
    else $error("irq without flag");
  a_cap_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fifo_out_valid && !do_de
    |=> cap_r[$past(fifo_out.index)] == $past(fifo_out.word)) else $error("capture word lost");
  a_de_no_defer: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cap_full_r |=> !cap_full_r) else $error("block boundary held over");
  a_rd_answer: assert property (@(posedge ref_clk) disable iff (!reset_n)
    host_req.rd |=> host_rvalid) else $error("read not answered");
  a_word_split: assert property (@(posedge ref_clk) disable iff (!reset_n)
    host_req.wr && host_hit && !host_req.addr[0]
    |=> host_r[$past(host_idx)][15:8] == $past(host_req.wdata)) else $error("a byte not written");
  a_tx_restart: assert property (@(posedge ref_clk) disable iff (!reset_n)
    tx_block_boundary |=> tx_idx_r == '0 && tx_bit_r == 3'h7)
    else $error("serialiser not restarted");
  c_de: cover property (@(posedge ref_clk) do_de);
  c_ef_professional: cover property (@(posedge ref_clk) do_ef && professional_a);
  c_reserve: cover property (@(posedge ref_clk) do_de && ctrl_r[csbuf_pkg::CTRL_RESERVE]);
  c_de_skipped: cover property (@(posedge ref_clk) cap_full_r && ctrl_r[csbuf_pkg::CTRL_INH_DE]);
  c_ef_skipped: cover property (@(posedge ref_clk)
    tx_block_boundary && ctrl_r[csbuf_pkg::CTRL_INH_EF]);
endmodule : chan_status_block_buffer
`default_nettype wire

// File: bench/host_model.sv
// host controller model driving the control port of the block buffer
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // clock
  input  wire logic                ref_clk,
  // control port
  output var csbuf_pkg::host_req_s host_req,
  output var logic                 run_enable,
  input  wire logic [7:0]          host_rdata,
  input  wire logic                host_rvalid
);
  initial begin
    host_req   = '0;
    run_enable = 1'b0;
  end
  // one-cycle request, released at the edge that takes it
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge ref_clk) host_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge ref_clk) host_req <= '0;
  endtask : wr
  // a missing answer returns unknown so any compare fails
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge ref_clk) host_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge ref_clk) host_req <= '0;
    #1;
    data = (host_rvalid === 1'b1) ? host_rdata : 8'hxx;
  endtask : rd
  task automatic run(input logic on);
    @(posedge ref_clk) run_enable <= on;
  endtask : run
endmodule : host_model
`default_nettype wire

// File: bench/tb_chan_status_block_buffer.sv
// self-checking testbench for the channel status block buffer
`timescale 1ns/100ps
`default_nettype none
module tb_chan_status_block_buffer;
  logic                ref_clk = 1'b0;
  logic                reset_n = 1'b0;
  logic                rx_bit_valid = 1'b0, rx_bit_a = 1'b0, rx_bit_b = 1'b0;
  logic                rx_block_start = 1'b0, rx_bit_ready;
  logic                tx_block_boundary = 1'b0, tx_bit_req = 1'b0, tx_bit_a, tx_bit_b;
  csbuf_pkg::host_req_s host_req;
  logic                run_enable, host_rvalid, irq;
  logic [7:0]          host_rdata, ga, gb, rv;
  logic                user_wr = 1'b0;
  logic [4:0]          user_index = 5'h00;
  logic [15:0]         user_wdata = 16'h0000, user_rdata;
  int                  miscompares = 0, samples_checked = 0;

  always #20 ref_clk = ~ref_clk;

  chan_status_block_buffer chan_status_block_buffer_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .rx_bit_valid(rx_bit_valid), .rx_bit_a(rx_bit_a), .rx_bit_b(rx_bit_b),
    .rx_block_start(rx_block_start), .rx_bit_ready(rx_bit_ready),
    .tx_block_boundary(tx_block_boundary), .tx_bit_req(tx_bit_req), .tx_bit_a(tx_bit_a),
    .tx_bit_b(tx_bit_b), .host_req(host_req), .run_enable(run_enable),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid), .user_wr(user_wr),
    .user_index(user_index), .user_wdata(user_wdata), .user_rdata(user_rdata), .irq(irq));

  host_model host_model_i (.ref_clk(ref_clk), .host_req(host_req), .run_enable(run_enable),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid));

  task automatic results();
    $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rdc(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    host_model_i.rd(addr, d);
    chk($sformatf("reg %h", addr), {8'h00, exp}, {8'h00, d});
  endtask : rdc

  // channel A byte i is seed+i, channel B its inverse
  task automatic cap(input logic [7:0] seed);
    logic [7:0] v;
    int         n;
    for (int i = 0; i < 24; i++) begin
      v = seed + 8'(i);
      for (int k = 7; k >= 0; k--) begin
        for (n = 0; n < 200 && rx_bit_ready !== 1'b1; n++) @(posedge ref_clk);
        if (n == 200) begin
          miscompares++;
          results();
        end
        @(posedge ref_clk) begin
          rx_bit_valid   <= 1'b1;
          rx_bit_a       <= v[k];
          rx_bit_b       <= ~v[k];
          rx_block_start <= (i == 0 && k == 7);
        end
        @(posedge ref_clk) rx_bit_valid <= 1'b0;
      end
    end
    repeat (60) @(posedge ref_clk);
  endtask : cap

  task automatic boundary();
    @(posedge ref_clk) tx_block_boundary <= 1'b1;
    @(posedge ref_clk) tx_block_boundary <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask : boundary

  function automatic logic [7:0] crc8(input logic [7:0] seed);
    logic [7:0] c, d;
    c = csbuf_pkg::CRC_INIT;
    for (int i = 0; i < 23; i++) begin
      d = seed + 8'(i);
      for (int k = 7; k >= 0; k--)
        c = {c[6:0], 1'b0} ^ ((c[7] ^ d[k]) ? csbuf_pkg::CRC_POLY : 8'h00);
    end
    return c;
  endfunction : crc8

  initial begin
    repeat (100000) @(posedge ref_clk);
    miscompares++;
    results();
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    rdc(csbuf_pkg::ADDR_CTRL, csbuf_pkg::RESET_CTRL);
    rdc(csbuf_pkg::ADDR_STATUS, 8'h00);
    host_model_i.wr(8'h20, 8'h5a);
    rdc(8'h20, 8'h00);
    host_model_i.run(1'b1);
    host_model_i.wr(8'h20, 8'ha5);
    host_model_i.wr(8'h21, 8'h3c);
    host_model_i.wr(8'h4f, 8'hc3);
    rdc(8'h20, 8'ha5);
    rdc(8'h21, 8'h3c);
    rdc(8'h4f, 8'hc3);
    rdc(8'h05, 8'h00);
    host_model_i.wr(csbuf_pkg::ADDR_CTRL, 8'h18);
    cap(8'h80);
    rdc(csbuf_pkg::ADDR_STATUS, 8'h01);
    chk("irq", 16'h0001, {15'h0000, irq});
    // reads start right after the capture interrupt, no inhibit needed
    for (int i = 0; i < 24; i++) begin
      rdc(8'h20 + 8'(2 * i), 8'h80 + 8'(i));
      rdc(8'h21 + 8'(2 * i), ~(8'h80 + 8'(i)));
    end
    host_model_i.wr(csbuf_pkg::ADDR_STATUS, 8'h01);
    // irq is registered from the flag, so it drops one edge after the flag clears
    repeat (2) @(posedge ref_clk);
    #1;
    chk("irq", 16'h0000, {15'h0000, irq});
    boundary();
    // a request loads the next bit, which then stands on the pin
    for (int i = 0; i < 24; i++) begin
      for (int k = 7; k >= 0; k--) begin
        @(posedge ref_clk) tx_bit_req <= 1'b1;
        @(posedge ref_clk) tx_bit_req <= 1'b0;
        @(posedge ref_clk);
        #1;
        ga[k] = tx_bit_a;
        gb[k] = tx_bit_b;
      end
      chk($sformatf("tx a %0d", i), {8'h00, (i == 23) ? crc8(8'h80) : 8'h80 + 8'(i)},
          {8'h00, ga});
      chk($sformatf("tx b %0d", i), {8'h00, ~(8'h80 + 8'(i))}, {8'h00, gb});
    end
    rdc(csbuf_pkg::ADDR_STATUS, 8'h02);
    host_model_i.wr(csbuf_pkg::ADDR_STATUS, 8'h03);
    host_model_i.wr(csbuf_pkg::ADDR_CTRL, 8'h1c);
    host_model_i.wr(8'h20, 8'h11);
    host_model_i.wr(8'h2a, 8'h22);
    cap(8'h40);
    rdc(8'h20, 8'h11);
    rdc(8'h28, 8'h84);
    rdc(8'h2a, 8'h45);
    host_model_i.wr(csbuf_pkg::ADDR_STATUS, 8'h03);
    host_model_i.wr(csbuf_pkg::ADDR_CTRL, 8'h1f);
    cap(8'h60);
    boundary();
    rdc(csbuf_pkg::ADDR_STATUS, 8'h00);
    rdc(8'h2a, 8'h45);
    chk("irq", 16'h0000, {15'h0000, irq});
    // lifting the inhibit must not replay the block that was skipped
    host_model_i.wr(csbuf_pkg::ADDR_CTRL, 8'h18);
    repeat (8) @(posedge ref_clk);
    rdc(csbuf_pkg::ADDR_STATUS, 8'h00);
    rdc(8'h2a, 8'h45);
    @(posedge ref_clk) begin
      user_wr    <= 1'b1;
      user_index <= 5'h03;
      user_wdata <= 16'hbeef;
    end
    @(posedge ref_clk) user_wr <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("user word", 16'hbeef, user_rdata);
    results();
  end
endmodule : tb_chan_status_block_buffer
`default_nettype wire
